//--- hw/radio_packet_rx_filter_codec.sv
// packet receive filter with crc, biphase and whitening codecs
`timescale 1ns/1ps
`include "rx_filter_cfg.svh"
module radio_packet_rx_filter_codec #(
   parameter int RATE_W = 8
) (
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [RATE_W-1:0] chip_rate_setting,
   input  wire logic              rx_enable,
   input  wire logic              rx_chip,
   input  wire logic [1:0]        sync_pattern_length,
   input  wire logic [2:0]        sync_error_tolerance,
   input  wire logic [31:0]       sync_pattern_value,
   input  wire logic              variable_length,
   input  wire logic [7:0]        max_frame_length,
   input  wire logic [7:0]        node_address,
   input  wire logic [1:0]        station_filter_sel,
   input  wire logic              checksum_enable,
   input  wire logic              bad_checksum_flush_enable,
   input  wire logic              biphase_code_enable,
   input  wire logic              scrambler_enable,
   input  wire logic              fifo_empty,
   output logic [7:0]             fifo_write_data,
   output logic                   fifo_write_valid,
   input  wire logic              fifo_write_ready,
   output logic                   fifo_clear,
   output logic                   sync_detected,
   output logic                   payload_ready,
   output logic                   crc_good,
   output logic                   crc_status,
   output logic                   address_match,
   input  wire logic              tx_bit,
   input  wire logic              tx_bit_valid,
   input  wire logic              tx_coded,
   input  wire logic              tx_payload,
   input  wire logic              tx_restart,
   output logic                   tx_bit_ready,
   output logic                   tx_chip,
   output logic [15:0]            tx_crc
);
   rx_filter_pkg::rx_state_e state;
   rx_filter_pkg::rx_state_e next_state;
   logic [RATE_W-1:0] div_cnt;
   logic              tick;
   logic              chip_meta;
   logic              chip;
   logic [31:0]       sync_sr;
   logic [31:0]       next_sync;
   logic              sync_hit;
   logic              half;
   logic              first_chip;
   logic              bit_strobe;
   logic              raw_bit;
   logic              plain_bit;
   logic [15:0]       rx_crc_calc;
   logic [2:0]        bit_cnt;
   logic [7:0]        byte_sr;
   logic [7:0]        new_byte;
   logic              byte_done;
   logic [7:0]        idx;
   logic [8:0]        total;
   logic [15:0]       rx_crc;
   logic              chk_second;
   logic              crc_pass;
   logic              is_len;
   logic              is_addr;
   logic              reject;
   logic              last;
   logic              discard;
   logic              pend_valid;
   logic [7:0]        pend_data;
   logic              tx_busy;
   logic              tx_half;
   logic              tx_b;
   logic              tx_man;
   logic              tx_plain;
   byte_stream_if     link ();

   function automatic logic [5:0] sync_errors(input logic [31:0] got,
                                              input logic [31:0] want,
                                              input logic [1:0]  len);
      logic [5:0] n;
      n = 6'h00;
      for (int i = 0; i < `RXF_SYNC_BITS; i++)
         if (i < (int'(len) + 1) * `RXF_BYTE_BITS && got[i] != want[i])
            n = n + 6'h01;
      return n;
   endfunction

   function automatic logic addr_ok(input logic [1:0] sel,
                                    input logic [7:0] a,
                                    input logic [7:0] node);
      case (rx_filter_pkg::station_filter_e'(sel))
         rx_filter_pkg::FILT_OFF:  addr_ok = 1'b1;
         rx_filter_pkg::FILT_NODE: addr_ok = a == node;
         rx_filter_pkg::FILT_ZERO: addr_ok = a == node
                                          || a == `RXF_BCAST_ZERO;
         rx_filter_pkg::FILT_BOTH: addr_ok = a == node
                                          || a == `RXF_BCAST_ZERO
                                          || a == `RXF_BCAST_ONES;
         default:                  addr_ok = 1'b0;
      endcase
   endfunction

   // chip rate enable
   assign tick = div_cnt == chip_rate_setting;
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         div_cnt <= '0;
      else
         div_cnt <= tick ? '0 : div_cnt + 1'b1;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         chip_meta <= 1'b0;
         chip      <= 1'b0;
      end else begin
         chip_meta <= rx_chip;
         chip      <= chip_meta;
      end
   end

   // sync hunt on raw nrz chips, same settings as transmit
   assign next_sync = {sync_sr[30:0], chip};
   assign sync_hit = tick && state == rx_filter_pkg::ST_HUNT
      && sync_errors(next_sync, sync_pattern_value, sync_pattern_length)
         <= {3'h0, sync_error_tolerance};
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         sync_sr <= 32'h0000_0000;
      else if (tick)
         sync_sr <= next_sync;
   end

   // biphase pairs decode on payload and checksum only
   assign bit_strobe = tick && (state == rx_filter_pkg::ST_BODY
      || state == rx_filter_pkg::ST_CHECK) && (!biphase_code_enable || half);
   assign raw_bit = biphase_code_enable ? first_chip : chip;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         half       <= 1'b0;
         first_chip <= 1'b0;
      end else if (sync_hit) begin
         half <= 1'b0;
      end else if (tick && biphase_code_enable) begin
         half       <= ~half;
         first_chip <= chip;
      end
   end

   bit_codec rx_codec (
      .clock       (clock),
      .rst         (rst),
      .restart     (sync_hit),
      .step        (bit_strobe),
      .bit_in      (raw_bit),
      .scramble_en (scrambler_enable),
      .crc_step    (state == rx_filter_pkg::ST_BODY),
      .crc_raw     (1'b0),
      .plain_bit   (plain_bit),
      .crc_value   (rx_crc_calc)
   );

   assign new_byte  = {byte_sr[6:0], plain_bit};
   assign byte_done = bit_strobe && bit_cnt == `RXF_BIT_LAST;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         bit_cnt <= 3'h0;
         byte_sr <= 8'h00;
      end else if (sync_hit) begin
         bit_cnt <= 3'h0;
      end else if (bit_strobe) begin
         bit_cnt <= bit_cnt + 3'h1;
         byte_sr <= new_byte;
      end
   end

   // per byte filtering
   assign is_len  = variable_length && idx == 8'h00;
   assign is_addr = station_filter_sel != rx_filter_pkg::FILT_OFF
      && idx == {7'h00, variable_length};
   assign reject = (is_len && new_byte >= max_frame_length)
      || (is_addr && !addr_ok(station_filter_sel, new_byte, node_address));
   assign last = is_len ? new_byte == 8'h00
                        : {1'b0, idx} + 9'h001 == total;
   assign crc_pass = {rx_crc[7:0], new_byte} == rx_crc_calc;
   assign discard = !rx_enable && state != rx_filter_pkg::ST_HOLD
                    && state != rx_filter_pkg::ST_IDLE ? 1'b0
      : (byte_done && state == rx_filter_pkg::ST_BODY && reject)
      || (byte_done && state == rx_filter_pkg::ST_CHECK && chk_second
          && checksum_enable && !crc_pass
          && bad_checksum_flush_enable);

   always_comb begin
      next_state = state;
      case (state)
         rx_filter_pkg::ST_IDLE:
            if (rx_enable && fifo_empty)
               next_state = rx_filter_pkg::ST_HUNT;
         rx_filter_pkg::ST_HUNT:
            if (sync_hit)
               next_state = rx_filter_pkg::ST_BODY;
         rx_filter_pkg::ST_BODY:
            if (byte_done && reject)
               next_state = rx_filter_pkg::ST_IDLE;
            else if (byte_done && last)
               next_state = checksum_enable ? rx_filter_pkg::ST_CHECK
                                            : rx_filter_pkg::ST_FINISH;
         rx_filter_pkg::ST_CHECK:
            if (discard)
               next_state = rx_filter_pkg::ST_IDLE;
            else if (byte_done && chk_second)
               next_state = rx_filter_pkg::ST_FINISH;
         rx_filter_pkg::ST_FINISH:
            if (!pend_valid && !fifo_write_valid)
               next_state = rx_filter_pkg::ST_HOLD;
         rx_filter_pkg::ST_HOLD:
            if (fifo_empty)
               next_state = rx_filter_pkg::ST_IDLE;
         default:
            next_state = rx_filter_pkg::ST_IDLE;
      endcase
      if (!rx_enable && state != rx_filter_pkg::ST_HOLD)
         next_state = rx_filter_pkg::ST_IDLE;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         state <= rx_filter_pkg::ST_IDLE;
      else
         state <= next_state;
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         idx        <= 8'h00;
         total      <= 9'h000;
         rx_crc     <= 16'h0000;
         chk_second <= 1'b0;
      end else if (sync_hit) begin
         idx        <= 8'h00;
         total      <= {1'b0, max_frame_length};
         chk_second <= 1'b0;
      end else if (byte_done) begin
         idx        <= idx + 8'h01;
         rx_crc     <= {rx_crc[7:0], new_byte};
         chk_second <= state == rx_filter_pkg::ST_CHECK;
         if (is_len && state == rx_filter_pkg::ST_BODY)
            total <= {1'b0, new_byte} + 9'h001;
      end
   end

   // payload bytes only; checksum bytes never pushed
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend_valid <= 1'b0;
         pend_data  <= 8'h00;
      end else if (discard) begin
         pend_valid <= 1'b0;
      end else if (byte_done && state == rx_filter_pkg::ST_BODY) begin
         pend_valid <= 1'b1;
         pend_data  <= new_byte;
      end else if (link.ready) begin
         pend_valid <= 1'b0;
      end
   end
   assign link.valid = pend_valid;
   assign link.data  = pend_data;

   frame_buffer buffer (
      .clock     (clock),
      .rst       (rst),
      .flush     (discard),
      .up        (link),
      .out_data  (fifo_write_data),
      .out_valid (fifo_write_valid),
      .out_ready (fifo_write_ready)
   );

   // ready, crc and address flags stand until the fifo has been read out; sync_detected and fifo_clear pulse one cycle
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fifo_clear    <= 1'b0;
         sync_detected <= 1'b0;
         payload_ready <= 1'b0;
         crc_good      <= 1'b0;
         crc_status    <= 1'b0;
         address_match <= 1'b0;
      end else begin
         fifo_clear    <= discard;
         sync_detected <= sync_hit;
         if (sync_hit)
            crc_status <= 1'b0;
         if (byte_done && state == rx_filter_pkg::ST_CHECK && chk_second)
            crc_status <= checksum_enable && crc_pass;
         if (state == rx_filter_pkg::ST_FINISH
             && next_state == rx_filter_pkg::ST_HOLD) begin
            payload_ready <= 1'b1;
            crc_good      <= checksum_enable && crc_status;
            address_match <= station_filter_sel
                             != rx_filter_pkg::FILT_OFF;
         end else if (state == rx_filter_pkg::ST_HOLD && fifo_empty) begin
            payload_ready <= 1'b0;
            crc_good      <= 1'b0;
            address_match <= 1'b0;
            if (rx_enable)
               crc_status <= 1'b0;
         end
      end
   end

   // transmit side: whitening, crc, biphase chips
   assign tx_man = biphase_code_enable && tx_coded;
   bit_codec tx_codec (
      .clock       (clock),
      .rst         (rst),
      .restart     (tx_restart),
      .step        (tx_bit_valid && tx_bit_ready),
      .bit_in      (tx_bit),
      .scramble_en (scrambler_enable && tx_coded),
      .crc_step    (checksum_enable && tx_payload),
      .crc_raw     (1'b1),
      .plain_bit   (tx_plain),
      .crc_value   (tx_crc)
   );

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_busy      <= 1'b0;
         tx_half      <= 1'b0;
         tx_b         <= 1'b0;
         tx_chip      <= 1'b0;
         tx_bit_ready <= 1'b1;
      end else if (tx_bit_valid && tx_bit_ready) begin
         tx_b         <= tx_plain;
         tx_busy      <= 1'b1;
         tx_bit_ready <= 1'b0;
      end else if (tick && tx_busy) begin
         tx_chip <= tx_half ? ~tx_b : tx_b;
         tx_half <= tx_man && !tx_half;
         if (!tx_man || tx_half) begin
            tx_busy      <= 1'b0;
            tx_bit_ready <= 1'b1;
         end
      end
   end

   a_sync_starts: assert property (@(posedge clock) disable iff (rst)
      sync_hit && rx_enable |=> state == rx_filter_pkg::ST_BODY
      && sync_detected) else $error("sync hit did not start capture");
   a_empty_first: assert property (@(posedge clock) disable iff (rst)
      state == rx_filter_pkg::ST_IDLE && !fifo_empty
      |=> state != rx_filter_pkg::ST_HUNT)
      else $error("hunt started with fifo not empty");
   a_len_discard: assert property (@(posedge clock) disable iff (rst)
      byte_done && state == rx_filter_pkg::ST_BODY && is_len && rx_enable
      && new_byte >= max_frame_length |=> fifo_clear && !pend_valid)
      else $error("overlong frame not discarded");
   a_addr_discard: assert property (@(posedge clock) disable iff (rst)
      byte_done && state == rx_filter_pkg::ST_BODY && is_addr && rx_enable
      && !addr_ok(station_filter_sel, new_byte, node_address)
      |=> fifo_clear) else $error("foreign address not discarded");
   a_flush_quiet: assert property (@(posedge clock) disable iff (rst)
      fifo_clear |-> !payload_ready && !crc_good ##1 (!rx_enable
      || state inside {rx_filter_pkg::ST_IDLE, rx_filter_pkg::ST_HUNT}))
      else $error("flags raised on flushed frame");
   a_good_ready: assert property (@(posedge clock) disable iff (rst)
      $rose(crc_good) |-> payload_ready && crc_status)
      else $error("crc good without payload ready");
   a_ready_stands: assert property (@(posedge clock) disable iff (rst)
      payload_ready && !(state == rx_filter_pkg::ST_HOLD && fifo_empty)
      |=> payload_ready) else $error("payload ready dropped early");
   a_no_crc_push: assert property (@(posedge clock) disable iff (rst)
      $rose(pend_valid) |-> $past(state) == rx_filter_pkg::ST_BODY)
      else $error("byte pushed outside payload");
   a_hold_idle: assert property (@(posedge clock) disable iff (rst)
      state == rx_filter_pkg::ST_HOLD |-> !fifo_write_valid && !pend_valid)
      else $error("fifo written after frame end");
endmodule

//--- pkg/rx_filter_cfg.svh
// constants of the packet receive filter and its codecs
`ifndef RX_FILTER_CFG_SVH
`define RX_FILTER_CFG_SVH
`define RXF_CRC_SEED   16'hffff
`define RXF_CRC_POLY   16'h1021
`define RXF_WHITE_SEED 9'h1ff
`define RXF_WHITE_TAP  5
`define RXF_BCAST_ZERO 8'h00
`define RXF_BCAST_ONES 8'hff
`define RXF_SYNC_BITS  32
`define RXF_BIT_LAST   3'h7
`define RXF_BYTE_BITS  8
`endif

//--- pkg/rx_filter_pkg.sv
// types of the packet receive filter
package rx_filter_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_HUNT   = 3'b001,
      ST_BODY   = 3'b010,
      ST_CHECK  = 3'b011,
      ST_FINISH = 3'b100,
      ST_HOLD   = 3'b101
   } rx_state_e;
   typedef enum logic [1:0] {
      FILT_OFF  = 2'b00,
      FILT_NODE = 2'b01,
      FILT_ZERO = 2'b10,
      FILT_BOTH = 2'b11
   } station_filter_e;
   typedef logic [7:0] byte_t;
endpackage

//--- pkg/byte_stream_if.sv
// byte stream with valid and ready between internal modules
`timescale 1ns/1ps
interface byte_stream_if;
   logic [7:0] data;
   logic       valid;
   logic       ready;
   modport source (output data, output valid, input ready);
   modport sink   (input data, input valid, output ready);
endinterface

//--- hw/bit_codec.sv
// whitening lfsr and crc-16 engine, one bit per step
`timescale 1ns/1ps
`include "rx_filter_cfg.svh"
module bit_codec (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        restart,
   input  wire logic        step,
   input  wire logic        bit_in,
   input  wire logic        scramble_en,
   input  wire logic        crc_step,
   input  wire logic        crc_raw,
   output logic             plain_bit,
   output logic [15:0]      crc_value
);
   logic [8:0] lfsr;
   logic       crc_src;
   logic       fb;

   assign plain_bit = bit_in ^ (scramble_en & lfsr[0]);
   assign crc_src   = crc_raw ? bit_in : plain_bit;
   assign fb        = crc_value[15] ^ crc_src;

   // x^9 + x^5 + 1, same seed on both ends
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         lfsr <= `RXF_WHITE_SEED;
      else if (restart)
         lfsr <= `RXF_WHITE_SEED;
      else if (step)
         lfsr <= {lfsr[0] ^ lfsr[`RXF_WHITE_TAP], lfsr[8:1]};
   end

   // ccitt crc, preset nonzero so leading zeros count
   always_ff @(posedge clock or posedge rst) begin
      if (rst)
         crc_value <= `RXF_CRC_SEED;
      else if (restart)
         crc_value <= `RXF_CRC_SEED;
      else if (step && crc_step)
         crc_value <= {crc_value[14:0], 1'b0}
                      ^ (fb ? `RXF_CRC_POLY : 16'h0000);
   end

   a_lfsr_alive: assert property (@(posedge clock) disable iff (rst)
      lfsr != 9'h000) else $error("whitening lfsr stuck at zero");
endmodule

//--- hw/frame_buffer.sv
// two-entry buffer between the receiver and the fifo write port
`timescale 1ns/1ps
module frame_buffer (
   input  wire logic        clock,
   input  wire logic        rst,
   input  wire logic        flush,
   byte_stream_if.sink      up,
   output logic [7:0]       out_data,
   output logic             out_valid,
   input  wire logic        out_ready
);
   logic [7:0] second;
   logic       full;
   logic       push;
   logic       pop;

   assign up.ready = ~full;
   assign push     = up.valid & ~full;
   assign pop      = out_valid & out_ready;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         out_valid <= 1'b0;
         full      <= 1'b0;
         out_data  <= 8'h00;
         second    <= 8'h00;
      end else if (flush) begin
         out_valid <= 1'b0;
         full      <= 1'b0;
      end else begin
         if (full && pop) begin
            out_data <= second;
            full     <= 1'b0;
         end else if (push && (!out_valid || pop)) begin
            out_data  <= up.data;
            out_valid <= 1'b1;
         end else if (push) begin
            second <= up.data;
            full   <= 1'b1;
         end else if (pop) begin
            out_valid <= 1'b0;
         end
      end
   end

   a_buf_holds: assert property (@(posedge clock) disable iff (rst)
      out_valid && !out_ready && !flush |=> out_valid && $stable(out_data))
      else $error("buffered byte changed while stalled");
endmodule

//--- test/fifo_partner.sv
// host-side fifo model with a randomly stalling write port
`timescale 1ns/1ps
module fifo_partner (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic [7:0] wr_data,
   input  wire logic       wr_valid,
   output logic            wr_ready,
   input  wire logic       clear,
   input  wire logic       rd_req,
   output logic [7:0]      rd_data,
   output logic            rd_valid,
   output logic            empty
);
   logic [7:0] mem[$];
   always @(posedge clock or posedge rst) begin
      rd_valid <= 1'b0;
      if (rst || clear) begin
         mem.delete();
      end else begin
         if (wr_valid && wr_ready) mem.push_back(wr_data);
         if (rd_req && mem.size() > 0) begin
            rd_data  <= mem.pop_front();
            rd_valid <= 1'b1;
         end
      end
      // stall one write cycle in four
      wr_ready <= ($urandom % 4) != 0;
      empty    <= mem.size() == 0;
   end
endmodule

//--- test/tb_radio_packet_rx_filter_codec.sv
// self-checking bench for the packet receive filter
`timescale 1ns/1ps
module tb_radio_packet_rx_filter_codec;
   logic clock, rst, rx_enable, rx_chip, variable_length, checksum_enable;
   logic bad_checksum_flush_enable, biphase_code_enable, scrambler_enable;
   logic fifo_empty, fifo_write_valid, fifo_write_ready, fifo_clear;
   logic sync_detected, payload_ready, crc_good, crc_status, address_match;
   logic rd_req, rd_valid, acc, tx_bit, tx_bit_valid, tx_coded;
   logic tx_payload, tx_restart, tx_bit_ready, tx_chip;
   logic [7:0]  chip_rate_setting, max_frame_length, node_address;
   logic [7:0]  fifo_write_data, rd_data;
   logic [7:0]  pay[16];
   logic [7:0]  adr[4];
   logic [1:0]  sync_pattern_length, station_filter_sel;
   logic [2:0]  sync_error_tolerance;
   logic [31:0] sync_pattern_value;
   logic [8:0]  lfsr;
   logic [15:0] tx_crc;
   logic [7:0]  exp_q[$];
   int          n_fail, comparisons, cycles, n_sync;
   radio_packet_rx_filter_codec DUT (.clock, .rst, .chip_rate_setting,
      .rx_enable, .rx_chip, .sync_pattern_length, .sync_error_tolerance,
      .sync_pattern_value, .variable_length, .max_frame_length,
      .node_address, .station_filter_sel, .checksum_enable,
      .bad_checksum_flush_enable, .biphase_code_enable, .scrambler_enable,
      .fifo_empty, .fifo_write_data, .fifo_write_valid, .fifo_write_ready,
      .fifo_clear, .sync_detected, .payload_ready, .crc_good, .crc_status,
      .address_match, .tx_bit, .tx_bit_valid, .tx_coded, .tx_payload,
      .tx_restart, .tx_bit_ready, .tx_chip, .tx_crc);
   fifo_partner far_end (.clock, .rst, .wr_data(fifo_write_data),
      .wr_valid(fifo_write_valid), .wr_ready(fifo_write_ready),
      .clear(fifo_clear), .rd_req, .rd_data, .rd_valid, .empty(fifo_empty));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   task automatic chk_flag(input logic got, input logic want);
      comparisons++;
      if (got !== want) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
      comparisons++;
      if (got !== want) begin
         n_fail++;
         $display("[ERR] t=%0t got %h exp %h", $time, got, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cycles++;
      if (sync_detected === 1'b1) n_sync++;
      if (rd_valid === 1'b1)
         chk_byte(rd_data, exp_q.size() ? exp_q.pop_front() : 8'hxx);
      if (cycles > 60000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chip(input logic c);
      rx_chip = c;
      repeat (4) @(negedge clock);
   endtask
   task automatic send_byte(input logic [7:0] b, input bit coded);
      logic d;
      for (int i = 7; i >= 0; i--) begin
         d = b[i];
         if (coded && scrambler_enable) begin
            d = d ^ lfsr[0];
            lfsr = {lfsr[0] ^ lfsr[5], lfsr[8:1]};
         end
         chip(d);
         if (coded && biphase_code_enable) chip(~d);
      end
   endtask
   function automatic logic [15:0] crc_of(input int n);
      logic [15:0] c;
      c = 16'hffff;
      for (int k = 0; k < n; k++)
         for (int i = 7; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ pay[k][i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction
   task automatic send_pkt(input int n, input bit bad, input bit serr,
                           input bit ok, input bit hit);
      logic [15:0] c;
      int          s;
      c = crc_of(n) ^ {15'h0, bad};
      s = n_sync;
      lfsr = 9'h1ff;
      repeat (2) send_byte(8'haa, 0);
      send_byte(8'h2d ^ {serr, 7'h0}, 0);
      send_byte(8'hd4, 0);
      for (int k = 0; k < n; k++) begin
         send_byte(pay[k], 1);
         if (ok) exp_q.push_back(pay[k]);
      end
      if (checksum_enable) begin
         send_byte(c[15:8], 1);
         send_byte(c[7:0], 1);
      end
      rx_chip = 1'b0;
      repeat (40) @(negedge clock);
      chk_flag(n_sync != s, hit);
   endtask
   task automatic tx_send(input logic b);
      tx_bit = b;
      tx_bit_valid = 1'b1;
      @(posedge clock);
      while (tx_bit_ready !== 1'b1) @(posedge clock);
      @(negedge clock);
      tx_bit_valid = 1'b0;
      while (tx_bit_ready !== 1'b1) @(negedge clock);
      chk_flag(tx_chip, b ^ (tx_coded & biphase_code_enable));
   endtask
   task automatic drain(input bit ok, input bit good, input bit am);
      chk_flag(payload_ready, ok);
      chk_flag(crc_good, good);
      chk_flag(crc_status, good);
      chk_flag(address_match, am);
      chk_flag(fifo_empty, !ok);
      rd_req = 1'b1;
      @(negedge clock);
      repeat (40) if (fifo_empty !== 1'b1) @(negedge clock);
      rd_req = 1'b0;
      repeat (6) @(negedge clock);
      chk_flag(payload_ready | crc_good | address_match, 1'b0);
      chk_flag(crc_status, 1'b0);
      chk_flag(exp_q.size() == 0, 1'b1);
      $display("test done at %0t", $time);
   endtask
   initial begin
      {rst, rx_enable, rx_chip, rd_req} = 4'b1000;
      {tx_bit, tx_bit_valid, tx_coded, tx_payload, tx_restart} = 5'b00000;
      {variable_length, biphase_code_enable, scrambler_enable} = 3'b000;
      {checksum_enable, bad_checksum_flush_enable} = 2'b11;
      {n_fail, comparisons, cycles, n_sync} = '0;
      chip_rate_setting = 8'h03;
      sync_pattern_length = 2'h1;
      sync_error_tolerance = 3'h0;
      sync_pattern_value = 32'h00002dd4;
      max_frame_length = 8'h03;
      node_address = 8'h5a;
      station_filter_sel = 2'h0;
      adr = '{8'h5a, 8'h00, 8'hff, 8'h3c};
      void'($urandom(32'h49e7127e));
      for (int k = 0; k < 16; k++) pay[k] = 8'($urandom);
      repeat (16) @(negedge clock);
      rst = 1'b0;
      rx_enable = 1'b1;
      send_pkt(3, 0, 0, 1, 1);
      drain(1, 1, 0);
      scrambler_enable = 1'b1;
      send_pkt(3, 0, 0, 1, 1);
      drain(1, 1, 0);
      {scrambler_enable, biphase_code_enable} = 2'b01;
      send_pkt(3, 0, 0, 1, 1);
      drain(1, 1, 0);
      biphase_code_enable = 1'b0;
      send_pkt(3, 0, 1, 0, 0);
      drain(0, 0, 0);
      sync_error_tolerance = 3'h1;
      send_pkt(3, 0, 1, 1, 1);
      drain(1, 1, 0);
      sync_error_tolerance = 3'h0;
      send_pkt(3, 1, 0, 0, 1);
      drain(0, 0, 0);
      bad_checksum_flush_enable = 1'b0;
      send_pkt(3, 1, 0, 1, 1);
      drain(1, 0, 0);
      checksum_enable = 1'b0;
      send_pkt(3, 0, 0, 1, 1);
      drain(1, 0, 0);
      {checksum_enable, bad_checksum_flush_enable} = 2'b11;
      for (int s = 1; s < 4; s++)
         foreach (adr[a]) begin
            station_filter_sel = 2'(s);
            pay[0] = adr[a];
            acc = adr[a] == node_address || (s > 1 && adr[a] == 8'h00)
                  || (s == 3 && adr[a] == 8'hff);
            send_pkt(3, 0, 0, acc, 1);
            drain(acc, acc, acc);
         end
      {station_filter_sel, variable_length, max_frame_length} = 11'h110;
      pay[0] = 8'h0f;
      send_pkt(16, 0, 0, 1, 1);
      drain(1, 1, 0);
      max_frame_length = 8'h05;
      pay[0] = 8'h05;
      send_pkt(6, 0, 0, 0, 1);
      drain(0, 0, 0);
      {variable_length, max_frame_length} = 9'h003;
      send_pkt(3, 0, 0, 1, 1);
      pay[1] = ~pay[1];
      send_pkt(3, 0, 0, 0, 0);
      pay[1] = ~pay[1];
      drain(1, 1, 0);
      tx_restart = 1'b1;
      @(negedge clock);
      {tx_restart, tx_payload} = 2'b01;
      for (int k = 0; k < 3; k++)
         for (int i = 7; i >= 0; i--) tx_send(pay[k][i]);
      tx_payload = 1'b0;
      chk_byte(8'(tx_crc >> 8), 8'(crc_of(3) >> 8));
      chk_byte(tx_crc[7:0], 8'(crc_of(3)));
      {biphase_code_enable, tx_coded} = 2'b11;
      tx_send(1'b1);
      tx_send(1'b0);
      $display("test done at %0t", $time);
      tally_and_finish();
   end
endmodule
